// ---- bench/flash_host_model.sv ----
// Host controller model that issues decoded commands to the die.
`timescale 1ns/10ps
`include "flash_protect_defs.vh"
module flash_host_model (
   input  wire        clk,
   output reg         cmd_valid,
   output reg  [3:0]  cmd_code,
   output reg  [24:0] cmd_addr,
   output reg  [7:0]  cmd_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
      cmd_addr = 25'h000_0000;
      cmd_data = 8'h00;
   end
   // One command is a one-cycle strobe; address and data flip afterwards so stale use shows up.
   task issue(input [3:0] code, input [24:0] addr, input [7:0] data);
      begin
         @(posedge clk);
         cmd_valid <= 1'b1;
         cmd_code <= code;
         cmd_addr <= addr;
         cmd_data <= data;
         @(posedge clk);
         cmd_valid <= 1'b0;
         cmd_addr <= ~addr;
         cmd_data <= ~data;
      end
   endtask
   // A write enable goes ahead of every write, program or erase.
   task write_cmd(input [3:0] code, input [24:0] addr, input [7:0] data);
      begin
         issue(`CMD_WRITE_ENABLE, 25'h000_0000, 8'h00);
         issue(code, addr, data);
      end
   endtask
endmodule // flash_host_model

// ---- bench/flash_status_protect_monitor.sv ----
// Checker of status lock, block protection and cycle timing at the die ports.
`timescale 1ns/10ps
`include "flash_protect_defs.vh"
module flash_status_protect_monitor #(parameter WRSR_CYCLES = 4, PROG_CYCLES = 6,
   ERASE_CYCLES = 8) (
   input wire       clk,
   input wire       rst_n,
   input wire       ce,
   input wire       write_protect_n,
   input wire       quad_io_protocol,
   input wire       cmd_valid,
   input wire [3:0] cmd_code,
   input wire       rsp_valid,
   input wire [7:0] rsp_data,
   input wire       cmd_refused,
   input wire       op_start,
   input wire [3:0] op_kind,
   input wire       busy,
   input wire       ready,
   input wire [7:0] status_and_protect,
   input wire [7:0] flag_status
);
   // Shorthands for the status fields and for a command taken while idle.
   wire [7:0] sr = status_and_protect;
   wire [3:0] size = {sr[6], sr[4:2]};
   wire go = cmd_valid && ce && !busy;
   wire wr = go && sr[1] && cmd_code == `CMD_WRITE_STATUS;
   wire lo = !write_protect_n && !quad_io_protocol;
   reg [15:0] run;
   // Busy cycles are counted so each internal cycle is judged by its length as it ends.
   always @(posedge clk)
      run <= (!rst_n || !busy) ? 16'h0000 : run + 16'h0001;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   reset_clear_a: assert property ($rose(rst_n) |-> sr == 8'h00 && flag_status == 8'h00)
      else $error("status not cleared by reset");
   ready_busy_a: assert property ($past(rst_n) |-> ready != busy && sr[0] == busy
      && flag_status[7] == ready) else $error("busy and ready disagree");
   lock_hold_a: assert property (wr && sr[7] && lo && $past(lo) && $past(lo, 2) && $past(lo, 3)
      && $past(rst_n, 3) |=> cmd_refused && $stable(sr[7:1]))
      else $error("locked status write went through");
   pin_release_a: assert property (wr && write_protect_n && $past(write_protect_n)
      && $past(write_protect_n, 2) |=> op_start && !cmd_refused)
      else $error("status write refused with pin high");
   quad_free_a: assert property (wr && quad_io_protocol |=> op_start)
      else $error("pin used for protection in quad protocol");
   prot_all_a: assert property (go && sr[1] && cmd_code == `CMD_PROGRAM && size >= 4'hA
      |=> cmd_refused && flag_status[1] && flag_status[4] && !sr[1])
      else $error("program into fully protected die not refused");
   die_guard_a: assert property (go && sr[1] && cmd_code == `CMD_DIE_ERASE && size != 4'h0
      |=> cmd_refused && flag_status[5] && !op_start)
      else $error("die erase with nonzero size code");
   read_back_a: assert property (cmd_valid && ce && cmd_code == `CMD_READ_STATUS
      |=> rsp_valid && rsp_data == $past(sr)) else $error("status read wrong");
   cycle_len_a: assert property ($fell(busy) |-> run == (op_kind == `CMD_PROGRAM ? PROG_CYCLES
      : (op_kind == `CMD_WRITE_STATUS || op_kind == `CMD_WRITE_NVCFG) ? WRSR_CYCLES
      : ERASE_CYCLES)) else $error("internal cycle length wrong");
endmodule // flash_status_protect_monitor
bind flash_status_protect flash_status_protect_monitor #(.WRSR_CYCLES(WRSR_CYCLES),
   .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) flash_status_protect_monitor_i (
   .clk, .rst_n, .ce, .write_protect_n, .quad_io_protocol, .cmd_valid, .cmd_code, .rsp_valid,
   .rsp_data, .cmd_refused, .op_start, .op_kind, .busy, .ready, .status_and_protect,
   .flag_status);

// ---- bench/flash_status_protect_tb.sv ----
// Self-checking bench for status register, write lock and block protection of one die.
`timescale 1ns/10ps
`include "flash_protect_defs.vh"
module flash_status_protect_tb;
   reg clk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, quad = 1'b0;
   wire cmd_valid, rsp_valid, cmd_refused, op_start, busy, ready;
   wire [3:0] cmd_code, op_kind;
   wire [24:0] cmd_addr, op_addr;
   wire [7:0] cmd_data, rsp_data, status_and_protect, flag_status;
   reg [7:0] exp_q[$];
   reg [28:0] op_q[$];
   reg [7:0] sr;
   reg [8:0] sec;
   reg [3:0] kind;
   reg [15:0] low;
   integer n_fail = 0, checked = 0, cyc = 0, c, n;
   // Short cycle counts keep the run brief; expectations follow these values.
   flash_status_protect #(.WRSR_CYCLES(4), .PROG_CYCLES(6), .ERASE_CYCLES(8))
      flash_status_protect_i (.clk, .rst_n, .ce(1'b1), .write_protect_n(wp_n),
      .quad_io_protocol(quad), .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .rsp_valid,
      .rsp_data, .cmd_refused, .op_start, .op_kind, .op_addr, .busy, .ready,
      .status_and_protect, .flag_status);
   flash_host_model flash_host_model_i (.clk, .cmd_valid, .cmd_code, .cmd_addr, .cmd_data);
   initial forever #10 clk = ~clk;
   task final_report;
      begin
         // A note still waiting at the end is an answer or a cycle that never came.
         if (exp_q.size() != 0 || op_q.size() != 0) n_fail = n_fail + 1;
         $display("checked %0d mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   // A hang is cut short well past the length of the full sequence.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail = n_fail + 1;
         final_report;
      end
   end
   task check_byte(input [7:0] e);
      begin
         checked = checked + 1;
         if (rsp_data !== e) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t read %h expected %h", $time, rsp_data, e);
         end
      end
   endtask
   // Each read answer takes the oldest note; an answer nobody asked for fails on x.
   always @(posedge clk)
      if (rsp_valid === 1'b1) check_byte(exp_q.size() ? exp_q.pop_front() : 8'hxx);
   task check_op(input [28:0] e);
      begin
         checked = checked + 1;
         if ({op_kind, op_addr} !== e) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t cycle %h expected %h", $time, {op_kind, op_addr}, e);
         end
      end
   endtask
   // Each started cycle takes the oldest note of kind and address; a stray start fails on x.
   always @(posedge clk)
      if (op_start === 1'b1) check_op(op_q.size() ? op_q.pop_front() : {29{1'bx}});
   task rd(input [3:0] code, input [7:0] e);
      begin
         exp_q.push_back(e);
         flash_host_model_i.issue(code, 25'h000_0000, 8'h00);
      end
   endtask
   task idle;
      begin
         @(posedge clk);
         while (busy !== 1'b0) @(posedge clk);
      end
   endtask
   initial begin
      void'($urandom(32'h77b0_b752));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(`CMD_READ_STATUS, 8'h00);
      rd(`CMD_READ_FLAGS, 8'h80);
      $display("reset test done");
      // Write disable drops the latch, so the program after it and an unknown code are refused.
      flash_host_model_i.issue(`CMD_WRITE_ENABLE, 25'h000_0000, 8'h00);
      flash_host_model_i.issue(`CMD_WRITE_DISABLE, 25'h000_0000, 8'h00);
      flash_host_model_i.issue(`CMD_PROGRAM, 25'h000_0000, 8'h00);
      flash_host_model_i.issue(4'hF, 25'h000_0000, 8'h00);
      rd(`CMD_READ_STATUS, 8'h00);
      // A configuration write runs four cycles here; both reads fall inside that cycle.
      op_q.push_back({`CMD_WRITE_NVCFG, 25'h0AB_CDEF});
      flash_host_model_i.write_cmd(`CMD_WRITE_NVCFG, 25'h0AB_CDEF, 8'h00);
      rd(`CMD_READ_STATUS, 8'h03);
      rd(`CMD_READ_FLAGS, 8'h00);
      idle;
      rd(`CMD_READ_STATUS, 8'h00);
      $display("command test done");
      // Every size code at both ends, probing the sectors on each side of the boundary.
      for (c = 0; c < 32; c = c + 1) begin
         sr = {1'b0, c[3], c[4], c[2:0], 2'b00};
         op_q.push_back({`CMD_WRITE_STATUS, 25'h000_0000});
         flash_host_model_i.write_cmd(`CMD_WRITE_STATUS, 25'h000_0000, sr);
         idle;
         rd(`CMD_READ_STATUS, sr);
         n = (c[3:0] == 0) ? 0 : (c[3:0] >= 10) ? 512 : 1 << (c[3:0] - 1);
         kind = `CMD_PROGRAM + 4'($urandom_range(3, 0));
         low = 16'($urandom);
         if (n > 0) begin
            sec = 9'(c[4] ? n - 1 : 512 - n);
            flash_host_model_i.write_cmd(kind, {sec, low}, 8'h00);
            rd(`CMD_READ_FLAGS, kind == `CMD_PROGRAM ? 8'h92 : 8'hA2);
            rd(`CMD_READ_STATUS, sr);
            flash_host_model_i.issue(`CMD_CLEAR_FLAGS, 25'h000_0000, 8'h00);
         end
         if (n < 512) begin
            sec = 9'(c[4] ? n : 511 - n);
            op_q.push_back({kind, sec, low});
            flash_host_model_i.write_cmd(kind, {sec, low}, 8'h00);
            idle;
            rd(`CMD_READ_FLAGS, 8'h80);
         end
         if (n == 0) op_q.push_back({`CMD_DIE_ERASE, 25'h000_0000});
         flash_host_model_i.write_cmd(`CMD_DIE_ERASE, 25'h000_0000, 8'h00);
         idle;
         rd(`CMD_READ_FLAGS, n > 0 ? 8'hA2 : 8'h80);
         flash_host_model_i.issue(`CMD_CLEAR_FLAGS, 25'h000_0000, 8'h00);
      end
      $display("protection test done");
      op_q.push_back({`CMD_WRITE_STATUS, 25'h000_0000});
      flash_host_model_i.write_cmd(`CMD_WRITE_STATUS, 25'h000_0000, 8'h80);
      idle;
      wp_n <= 1'b0;
      repeat (3) @(posedge clk);
      flash_host_model_i.write_cmd(`CMD_WRITE_STATUS, 25'h000_0000, 8'h00);
      rd(`CMD_READ_STATUS, 8'h82);
      quad <= 1'b1;
      op_q.push_back({`CMD_WRITE_STATUS, 25'h000_0000});
      flash_host_model_i.issue(`CMD_WRITE_STATUS, 25'h000_0000, 8'h84);
      idle;
      rd(`CMD_READ_STATUS, 8'h84);
      quad <= 1'b0;
      flash_host_model_i.write_cmd(`CMD_WRITE_STATUS, 25'h000_0000, 8'h00);
      rd(`CMD_READ_STATUS, 8'h86);
      wp_n <= 1'b1;
      repeat (3) @(posedge clk);
      op_q.push_back({`CMD_WRITE_STATUS, 25'h000_0000});
      flash_host_model_i.issue(`CMD_WRITE_STATUS, 25'h000_0000, 8'h00);
      idle;
      rd(`CMD_READ_STATUS, 8'h00);
      repeat (3) @(posedge clk);
      $display("lock test done");
      final_report;
   end
endmodule // flash_status_protect_tb

// ---- include/flash_protect_defs.vh ----
// Constants shared by the status register and block protection logic.
`ifndef FLASH_PROTECT_DEFS_VH
`define FLASH_PROTECT_DEFS_VH

// Status register field positions.
`define SR_LOCK_BIT       7
`define SR_SIZE3_BIT      6
`define SR_TOPBOT_BIT     5
`define SR_SIZE_LO_MSB    4
`define SR_SIZE_LO_LSB    2
`define SR_WEL_BIT        1
`define SR_BUSY_BIT       0
`define SR_RESET          8'h00

// Flag status register field positions.
`define FS_READY_BIT      7
`define FS_ERASE_ERR_BIT  5
`define FS_PROG_ERR_BIT   4
`define FS_PROT_ERR_BIT   1
`define FS_RESET          8'h00

// Command codes on the decoded command port.
`define CMD_WRITE_ENABLE  4'h1
`define CMD_WRITE_DISABLE 4'h2
`define CMD_READ_STATUS   4'h3
`define CMD_WRITE_STATUS  4'h4
`define CMD_PROGRAM       4'h5
`define CMD_ERASE_SECTOR  4'h6
`define CMD_ERASE_SUB32   4'h7
`define CMD_ERASE_SUB4    4'h8
`define CMD_DIE_ERASE     4'h9
`define CMD_READ_FLAGS    4'hA
`define CMD_CLEAR_FLAGS   4'hB
`define CMD_WRITE_NVCFG   4'hC

// Array geometry of one die: 512 sectors of 64KB.
`define ADDR_W            25
`define SECTOR_MSB        24
`define SECTOR_LSB        16
`define SECTOR_W          9
`define SIZE_ALL_CODE     4'hA

// Internal cycle times in ns and the clock period they are counted in.
`define CLK_PERIOD_NS     20
`define WRSR_TIME_NS      1000
`define PROG_TIME_NS      2000
`define ERASE_TIME_NS     8000

`endif

// ---- rtl/flash_status_protect.v ----
// Status register, write lock and block protection of one flash die.
//
// Summary of operation
// - Protected sectors refuse program and erase.
// - Lock bit plus low pin freezes status.
// - A high pin or quad protocol ends hardware lock.
// - Bit 7 is the nonvolatile status write lock.
// - Size code sits at bits 6, 4:2.
// - Size code selects power-of-two sector count.
// - Write-enable latch clears at power-up.
// - Bit 0 shows an internal cycle running.
// - Busy bit is inverse of flag ready from first enabled clock after reset.
// - Die erase only with zero size code.
// - Die holds 512 sectors of 64KB.
// - Status and flag read commands are answered.
// - Protect pin is data in quad protocol.
// - Protected access sets protection error flag.
`timescale 1ns/10ps
`include "flash_protect_defs.vh"

module flash_status_protect #(
   parameter ADDR_W      = `ADDR_W,
   parameter CNT_W       = 16,
   parameter WRSR_CYCLES = (`WRSR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter PROG_CYCLES = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter ERASE_CYCLES = (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input  wire              clk,
   input  wire              rst_n,
   input  wire              ce,
   input  wire              write_protect_n,
   input  wire              quad_io_protocol,
   input  wire              cmd_valid,
   input  wire [3:0]        cmd_code,
   input  wire [ADDR_W-1:0] cmd_addr,
   input  wire [7:0]        cmd_data,
   output reg               rsp_valid,
   output reg  [7:0]        rsp_data,
   output reg               cmd_refused,
   output reg               op_start,
   output reg  [3:0]        op_kind,
   output reg  [ADDR_W-1:0] op_addr,
   output reg               busy,
   output reg               ready,
   output reg  [7:0]        status_and_protect,
   output reg  [7:0]        flag_status
);

   // Cycle lengths are cut to the counter width on purpose. A length that overflows
   // CNT_W would shorten the cycle, so widen CNT_W before lengthening the timing defines.
   localparam [CNT_W-1:0] WRSR_CNT  = WRSR_CYCLES[CNT_W-1:0];
   localparam [CNT_W-1:0] PROG_CNT  = PROG_CYCLES[CNT_W-1:0];
   localparam [CNT_W-1:0] ERASE_CNT = ERASE_CYCLES[CNT_W-1:0];

   // Two-stage synchroniser for the write-protect pin.
   reg wp_meta;
   reg wp_sync;

   // Cycles left in the running internal operation; it counts down to one.
   reg [CNT_W-1:0] busy_cnt;

   // Decoded views of the status bits and of the command on the port.
   wire [3:0] protect_size_code;
   wire       top_bottom;
   wire       lock_bit;
   wire       wel;
   wire       sector_hit;
   wire       hw_locked;
   wire       is_prog;
   wire       is_erase;
   wire       is_array_op;
   wire       die_blocked;

   // Field views of the status register; the size code is split around bit 5.
   assign protect_size_code = {status_and_protect[`SR_SIZE3_BIT],
      status_and_protect[`SR_SIZE_LO_MSB:`SR_SIZE_LO_LSB]};
   assign top_bottom = status_and_protect[`SR_TOPBOT_BIT];
   assign lock_bit   = status_and_protect[`SR_LOCK_BIT];
   assign wel        = status_and_protect[`SR_WEL_BIT];

   // In quad protocol the pin carries data, so it never locks anything.
   // The size code still guards the array then; only status writes are unlocked.
   assign hw_locked = lock_bit & ~wp_sync & ~quad_io_protocol;

   // Command class decode. Subsector erases are judged by the 64KB sector around them,
   // so a protected sector also guards every 4KB and 32KB piece inside it.
   assign is_prog     = (cmd_code == `CMD_PROGRAM);
   assign is_erase    = (cmd_code == `CMD_ERASE_SECTOR) | (cmd_code == `CMD_ERASE_SUB32) |
                        (cmd_code == `CMD_ERASE_SUB4);
   assign is_array_op = is_prog | is_erase;
   assign die_blocked = (cmd_code == `CMD_DIE_ERASE) &
                        (protect_size_code != 4'h0);

   // Sector index is bits 24:16 of the die address, 512 sectors of 64KB.
   protect_range_check #(
      .SECTOR_W          (`SECTOR_W)
   ) u_range (
      .protect_size_code (protect_size_code),
      .top_bottom        (top_bottom),
      .sector            (cmd_addr[`SECTOR_MSB:`SECTOR_LSB]),
      .hit               (sector_hit)
   );

   // The pin is asynchronous to clk, so only the second stage is used.
   // Both stages reset high, so the die starts unprotected until the real level arrives.
   always @(posedge clk) begin
      if (!rst_n) begin
         wp_meta <= 1'b1;
         wp_sync <= 1'b1;
      end else if (ce) begin
         wp_meta <= write_protect_n;
         wp_sync <= wp_meta;
      end
   end

   // Command handling, internal cycle timer and both status registers.
   always @(posedge clk) begin
      if (!rst_n) begin
         status_and_protect <= `SR_RESET;
         flag_status        <= `FS_RESET;
         busy               <= 1'b0;
         ready              <= 1'b1;
         busy_cnt           <= {CNT_W{1'b0}};
         rsp_valid          <= 1'b0;
         rsp_data           <= 8'h00;
         cmd_refused        <= 1'b0;
         op_start           <= 1'b0;
         op_kind            <= 4'h0;
         op_addr            <= {ADDR_W{1'b0}};
      end else if (ce) begin
         // Pulses last one cycle; the held outputs keep their last value.
         rsp_valid   <= 1'b0;
         cmd_refused <= 1'b0;
         op_start    <= 1'b0;
         flag_status[`FS_READY_BIT] <= ~busy;
         // The internal cycle ends when the timer runs out; the latch drops then.
         if (busy) begin
            if (busy_cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
               busy     <= 1'b0;
               ready    <= 1'b1;
               busy_cnt <= {CNT_W{1'b0}};
               status_and_protect[`SR_BUSY_BIT] <= 1'b0;
               status_and_protect[`SR_WEL_BIT]  <= 1'b0;
               flag_status[`FS_READY_BIT]       <= 1'b1;
            end else begin
               busy_cnt <= busy_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
         // One command is taken per cycle, so a flag is never set and cleared at once.
         if (cmd_valid) begin
            // Reads are answered even while an internal cycle runs.
            if (cmd_code == `CMD_READ_STATUS) begin
               rsp_valid <= 1'b1;
               rsp_data  <= status_and_protect;
            end else if (cmd_code == `CMD_READ_FLAGS) begin
               rsp_valid <= 1'b1;
               rsp_data  <= {~busy, flag_status[6:0]};
            end else if (busy) begin
               // A running cycle owns the array; only reads get through.
               cmd_refused <= 1'b1;
            end else if (cmd_code == `CMD_WRITE_ENABLE) begin
               status_and_protect[`SR_WEL_BIT] <= 1'b1;
            end else if (cmd_code == `CMD_WRITE_DISABLE) begin
               status_and_protect[`SR_WEL_BIT] <= 1'b0;
            end else if (cmd_code == `CMD_CLEAR_FLAGS) begin
               flag_status[`FS_ERASE_ERR_BIT] <= 1'b0;
               flag_status[`FS_PROG_ERR_BIT]  <= 1'b0;
               flag_status[`FS_PROT_ERR_BIT]  <= 1'b0;
            end else if (!wel) begin
               // Without the latch no write, program or erase may start.
               cmd_refused <= 1'b1;
            end else if (cmd_code == `CMD_WRITE_STATUS) begin
               if (hw_locked) begin
                  cmd_refused <= 1'b1;
               end else begin
                  // Only the nonvolatile bits take the written value.
                  status_and_protect[7:2] <= cmd_data[7:2];
                  status_and_protect[`SR_BUSY_BIT] <= 1'b1;
                  busy     <= 1'b1;
                  ready    <= 1'b0;
                  busy_cnt <= WRSR_CNT;
                  flag_status[`FS_READY_BIT] <= 1'b0;
                  op_start <= 1'b1;
                  op_kind  <= cmd_code;
                  op_addr  <= {ADDR_W{1'b0}};
               end
            end else if ((is_array_op && sector_hit) || die_blocked) begin
               // Refused before any cycle starts; the latch is dropped as well.
               cmd_refused <= 1'b1;
               status_and_protect[`SR_WEL_BIT] <= 1'b0;
               flag_status[`FS_PROT_ERR_BIT]   <= 1'b1;
               // The error bit beside it names the kind of operation that was tried.
               if (is_prog) begin
                  flag_status[`FS_PROG_ERR_BIT] <= 1'b1;
               end else begin
                  flag_status[`FS_ERASE_ERR_BIT] <= 1'b1;
               end
            end else if (is_array_op || (cmd_code == `CMD_DIE_ERASE) ||
                         (cmd_code == `CMD_WRITE_NVCFG)) begin
               status_and_protect[`SR_BUSY_BIT] <= 1'b1;
               busy     <= 1'b1;
               ready    <= 1'b0;
               flag_status[`FS_READY_BIT] <= 1'b0;
               op_start <= 1'b1;
               op_kind  <= cmd_code;
               op_addr  <= cmd_addr;
               // The configuration write shares the status write time.
               if (is_prog) begin
                  busy_cnt <= PROG_CNT;
               end else if (cmd_code == `CMD_WRITE_NVCFG) begin
                  busy_cnt <= WRSR_CNT;
               end else begin
                  busy_cnt <= ERASE_CNT;
               end
            end else begin
               // Unknown codes are refused and change nothing.
               cmd_refused <= 1'b1;
            end
         end
      end
   end

endmodule // flash_status_protect

// ---- rtl/protect_range_check.v ----
// Decoder that tells whether a 64KB sector lies in the protected area.
`timescale 1ns/10ps
`include "flash_protect_defs.vh"

module protect_range_check #(
   parameter SECTOR_W = `SECTOR_W
) (
   input  wire [3:0]          protect_size_code,
   input  wire                top_bottom,
   input  wire [SECTOR_W-1:0] sector,
   output reg                 hit
);

   reg [SECTOR_W:0] span;
   reg [SECTOR_W:0] sector_ext;

   // Size code 0 protects nothing, 1..9 protect 2^(code-1) sectors, above that all.
   always @* begin
      span       = {(SECTOR_W+1){1'b0}};
      sector_ext = {1'b0, sector};
      if (protect_size_code >= `SIZE_ALL_CODE) begin
         span = {1'b1, {SECTOR_W{1'b0}}};
      end else if (protect_size_code != 4'h0) begin
         span = {{SECTOR_W{1'b0}}, 1'b1} << (protect_size_code - 4'h1);
      end
      if (top_bottom) begin
         hit = (sector_ext < span);
      end else begin
         hit = (sector_ext >= ({1'b1, {SECTOR_W{1'b0}}} - span));
      end
   end

endmodule // protect_range_check
